// [bench/slc_app_model.sv]
`timescale 1ns/10ps
`default_nettype none
module slc_app_model
  (
  input  wire logic        mclk,
  output var  logic        link_connected,
  output var  logic        unlock_req,
  output var  logic [23:0] unlock_pw,
  output var  logic        pw_change_req,
  output var  logic [23:0] pw_old,
  output var  logic [23:0] pw_new,
  output var  logic        name_change_req,
  output var  logic [63:0] name_new
  );
  initial
  begin
    {link_connected, unlock_req, pw_change_req, name_change_req} = 4'h0;
    {unlock_pw, pw_old, pw_new, name_new} = 136'h0;
  end
  task automatic link(input logic up);
    link_connected = up;
    @(posedge mclk);
    #1;
  endtask
  // released data lines end up inverted; change keeps pw_old and pw_new at their last value through its name cycle
  task automatic unlock(input logic [23:0] pw);
    unlock_req = 1'h1;
    unlock_pw = pw;
    @(posedge mclk);
    #1;
    unlock_req = 1'h0;
    unlock_pw = ~pw;
  endtask
  task automatic change(input logic [23:0] o, input logic [23:0] n, input logic [63:0] nm);
    pw_change_req = 1'h1;
    pw_old = o;
    pw_new = n;
    @(posedge mclk);
    #1;
    pw_change_req = 1'h0;
    name_change_req = 1'h1;
    name_new = nm;
    @(posedge mclk);
    #1;
    name_change_req = 1'h0;
    {pw_old, pw_new, name_new} = ~{o, n, nm};
  endtask
endmodule // slc_app_model
`default_nettype wire

// [bench/slc_lock_ctrl_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module slc_lock_ctrl_asserts
  #(parameter TICK_CYCLES = 250000)
  (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        link_connected,
  input wire logic        unlock_req,
  input wire logic [23:0] unlock_pw,
  input wire logic        pw_change_req,
  input wire logic [23:0] pw_old,
  input wire logic [23:0] pw_new,
  input wire logic        motor_current_edge_in,
  input wire logic        chain_break_edge_in,
  input wire logic        motor_cw,
  input wire logic        motor_ccw,
  input wire logic        buzzer,
  input wire logic        locked,
  input wire logic [23:0] nv_password,
  input wire logic        nv_write
  );
  // alarm may wait for the next tick, plus the output register
  localparam int BZ = TICK_CYCLES + 3;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // ==========================================
  // motor
  sequence s_idle;
    !motor_cw && !motor_ccw;
  endsequence
  sequence s_go;
    unlock_req && link_connected && locked && unlock_pw == nv_password;
  endsequence
  AST_EXCL: assert property (!(motor_cw && motor_ccw)) else $error("both drives on");
  AST_CW_GO: assert property (s_idle ##0 s_go |=> motor_cw) else $error("no unlock");
  AST_STOP: assert property ((motor_cw || motor_ccw) && $rose(motor_current_edge_in)
    |=> s_idle) else $error("motor not stopped");
  AST_UNLOCKED: assert property ($fell(motor_cw) |-> !locked) else $error("state stale");
  AST_LOCKED: assert property ($fell(motor_ccw) |-> locked) else $error("not locked");
  // ==========================================
  // alarm and password
  AST_ALARM: assert property (s_idle ##0
    (locked && !link_connected && $rose(chain_break_edge_in))
    |-> ##[1:BZ] (buzzer || link_connected)) else $error("no alarm");
  AST_DISARM: assert property ($rose(link_connected) && !$rose(chain_break_edge_in)
    |-> ##2 !buzzer) else $error("alarm kept");
  AST_PW: assert property (link_connected && pw_change_req && pw_old == nv_password
    |=> nv_write && nv_password == $past(pw_new)) else $error("password not stored");
endmodule // slc_lock_ctrl_asserts
bind slc_lock_ctrl slc_lock_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_slc_lock_ctrl_asserts (.*);
`default_nettype wire

// [bench/slc_lock_ctrl_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module slc_lock_ctrl_tb;
  localparam int TK = 10;
  localparam int ADC_TICKS = 100;
  logic             mclk, reset, lock_key, motor_current_edge_in, chain_break_edge_in, adc_valid;
  logic [9:0]       adc_data, battery_level;
  wire logic        link_connected, unlock_req, pw_change_req, name_change_req;
  wire logic [23:0] unlock_pw, pw_old, pw_new;
  wire logic [63:0] name_new;
  logic             adc_start, motor_cw, motor_ccw, buzzer, link_led, locked, auth_ok, nv_write;
  logic [23:0]      nv_password, pw, nxt;
  logic [63:0]      adv_name, nm;
  int               miscompares, checked, n;
  slc_lock_ctrl #(.TICK_CYCLES(TK)) u_slc_lock_ctrl (.*);
  slc_app_model u_slc_app_model (.*);
  // ==========================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [23:0] bcd6();
    for (int i = 0; i < 6; i++)
      bcd6[i*4 +: 4] = 4'($urandom % 10);
  endfunction
  task automatic stop_motor;
    motor_current_edge_in = 1'h1;
    cyc(1);
    motor_current_edge_in = 1'h0;
    cyc(1);
  endtask
  // ==========================================
  // clock, watchdog, tests
  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    final_report;
  end
  initial
  begin
    {reset, lock_key, motor_current_edge_in, chain_break_edge_in, adc_valid} = 5'h10;
    adc_data = 10'h000;
    void'($urandom(32'h3491));
    cyc(20);
    reset = 1'h0;
    chk("locked", 1, locked);
    chk("motor", 0, {motor_cw, motor_ccw});
    u_slc_app_model.link(1'h1);
    u_slc_app_model.unlock(bcd6() | 24'h000001);
    cyc(2);
    chk("cw_bad_pw", 0, motor_cw);
    pw = 24'h000000;
    repeat (2)
    begin
      u_slc_app_model.unlock(pw);
      cyc(1);
      chk("cw", 1, motor_cw);
      chk("auth", 1, auth_ok);
      stop_motor;
      chk("cw_stop", 0, motor_cw);
      chk("unlocked", 0, locked);
      u_slc_app_model.link(1'h0);
      lock_key = 1'h1;
      cyc(5 * TK);
      chk("ccw", 1, motor_ccw);
      lock_key = 1'h0;
      // let the release debounce so the next press is seen
      cyc(4 * TK);
      stop_motor;
      chk("relocked", 1, locked);
      u_slc_app_model.link(1'h1);
      cyc(1);
      chk("led", 1, link_led);
      nxt = bcd6();
      nm = {$urandom, $urandom};
      u_slc_app_model.change(pw ^ 24'h000001, nxt, nm);
      chk("pw_kept", pw, nv_password);
      cyc(1);
      u_slc_app_model.change(pw, nxt, nm);
      chk("pw_new", nxt, nv_password);
      chk("name", nm, adv_name);
      pw = nxt;
    end
    u_slc_app_model.link(1'h0);
    chain_break_edge_in = 1'h1;
    cyc(TK + 3);
    chk("buzzer_on", 1, buzzer);
    cyc(10 * TK);
    chk("buzzer_held", 1, buzzer);
    u_slc_app_model.link(1'h1);
    cyc(2);
    chk("buzzer_off", 0, buzzer);
    chain_break_edge_in = 1'h0;
    repeat (3)
    begin
      adc_data = 10'($urandom);
      adc_valid = 1'h1;
      cyc(1);
      adc_valid = 1'h0;
      cyc(1);
      chk("battery", adc_data, battery_level);
    end
    // sample strobe spacing in cycles
    n = 0;
    while (adc_start !== 1'h1 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    cyc(1);
    n = 1;
    while (adc_start !== 1'h1 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    chk("adc_period", ADC_TICKS * TK, n);
    // no end stop: only the tick-based timeout ends the run
    u_slc_app_model.unlock(pw);
    cyc(290 * TK);
    chk("cw_run", 1, motor_cw);
    cyc(15 * TK);
    chk("cw_timeout", 0, motor_cw);
    chk("unlocked_to", 0, locked);
    final_report;
  end
endmodule // slc_lock_ctrl_tb
`default_nettype wire

// [hdl/slc_defs.vh]
`ifndef SLC_DEFS_VH
`define SLC_DEFS_VH
// ==========================================================
// clock and tick timing
`define SLC_CLK_HZ        25000000
`define SLC_TICK_MS       10
`define SLC_TICK_CYCLES   ((`SLC_CLK_HZ / 1000) * `SLC_TICK_MS)
`define SLC_TICK_W        18
// ==========================================================
// debounce, motor timeout, buzzer cadence in ticks
`define SLC_DEB_TICKS     3
`define SLC_MOTOR_TICKS   300
`define SLC_BUZZ_TICKS    25
`define SLC_BUZZ_LAST     9'h018
`define SLC_TCNT_W        9
// ==========================================================
// motor states
`define SLC_ST_IDLE       2'h0
`define SLC_ST_CW         2'h1
`define SLC_ST_CCW        2'h2
// ==========================================================
// reset values, adc width and sample period
`define SLC_PW_RESET      24'h000000
`define SLC_NAME_RESET    64'h0000000000000000
`define SLC_ADC_W         10
`define SLC_ADC_PERIOD    8'h64
`endif

// [hdl/slc_lock_ctrl.v]
`timescale 1ns/10ps
`default_nettype none
`include "slc_defs.vh"
// Contract
// (RULE_01) unlock needs matching password first; report state
// (RULE_02) unlock request while locked drives clockwise
// (RULE_03) lock key while unlocked drives counter-clockwise
// (RULE_04) local locking ignores link connection
// (RULE_05) motor current edge stops the motor
// (RULE_06) chain break edge while locked alarms; code alarms only while the motor is idle
// (RULE_07) alarm holds until link connects
// (RULE_08) state and battery outputs kept current
// (RULE_09) battery level sampled from adc input
// (RULE_10) password change stores new 6-digit password
// (RULE_11) name change stores and advertises name; code drops the name when a password change is stored in the same cycle
// (RULE_12) led shows link state
// (RULE_13) 10 ms tick times debounce, motor, buzzer
// (RULE_14) never both motor directions at once
module slc_lock_ctrl
  #(parameter TICK_CYCLES = `SLC_TICK_CYCLES)
  (
  input  wire        mclk,
  input  wire        reset,
  input  wire        link_connected,
  input  wire        unlock_req,
  input  wire [23:0] unlock_pw,
  input  wire        pw_change_req,
  input  wire [23:0] pw_old,
  input  wire [23:0] pw_new,
  input  wire        name_change_req,
  input  wire [63:0] name_new,
  input  wire        lock_key,
  input  wire        motor_current_edge_in,
  input  wire        chain_break_edge_in,
  input  wire [9:0]  adc_data,
  input  wire        adc_valid,
  output reg         adc_start,
  output reg         motor_cw,
  output reg         motor_ccw,
  output reg         buzzer,
  output reg         link_led,
  output reg         locked,
  output reg         auth_ok,
  output reg  [9:0]  battery_level,
  output reg  [23:0] nv_password,
  output reg  [63:0] adv_name,
  output reg         nv_write
  );

  // ==========================================================
  // tick
  wire tick;

  slc_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .mclk  (mclk),
    .reset (reset),
    .tick  (tick)
  );

  // ==========================================================
  // edge detection
  reg mc_prev;
  reg ch_prev;
  reg link_prev;
  wire mc_edge   = motor_current_edge_in & ~mc_prev;
  wire ch_edge   = chain_break_edge_in & ~ch_prev;
  wire link_rise = link_connected & ~link_prev;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      mc_prev   <= 1'b0;
      ch_prev   <= 1'b0;
      link_prev <= 1'b0;
    end
    else
    begin
      mc_prev   <= motor_current_edge_in;
      ch_prev   <= chain_break_edge_in;
      link_prev <= link_connected;
    end
  end

  // ==========================================================
  // lock key debounce
  reg [1:0] deb_cnt;
  reg       key_stable;
  reg       key_press;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      deb_cnt    <= 2'h0;
      key_stable <= 1'b0;
      key_press  <= 1'b0;
    end
    else
    begin
      key_press <= 1'b0;
      if (tick) // RULE_13
      begin
        if (lock_key == key_stable)
          deb_cnt <= 2'h0;
        else if (deb_cnt == `SLC_DEB_TICKS - 1)
        begin
          deb_cnt    <= 2'h0;
          key_stable <= lock_key;
          key_press  <= lock_key;
        end
        else
          deb_cnt <= deb_cnt + 2'h1;
      end
    end
  end

  // ==========================================================
  // authentication and nonvolatile store
  always @(posedge mclk)
  begin
    if (reset)
    begin
      auth_ok     <= 1'b0;
      nv_password <= `SLC_PW_RESET;
      adv_name    <= `SLC_NAME_RESET;
      nv_write    <= 1'b0;
    end
    else
    begin
      nv_write <= 1'b0;
      if (!link_connected)
        auth_ok <= 1'b0;
      else if (unlock_req && unlock_pw == nv_password)
        auth_ok <= 1'b1; // RULE_01
      if (link_connected && pw_change_req && pw_old == nv_password)
      begin
        nv_password <= pw_new; // RULE_10
        nv_write    <= 1'b1;
      end
      else if (link_connected && name_change_req)
      begin
        adv_name <= name_new; // RULE_11
        nv_write <= 1'b1;
      end
    end
  end

  // ==========================================================
  // motor control
  reg [1:0]            mstate;
  reg [`SLC_TCNT_W-1:0] mtime;
  wire pw_match = unlock_pw == nv_password;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      mstate    <= `SLC_ST_IDLE;
      mtime     <= {`SLC_TCNT_W{1'b0}};
      motor_cw  <= 1'b0;
      motor_ccw <= 1'b0;
      locked    <= 1'b1;
    end
    else
    begin
      case (mstate)
        `SLC_ST_IDLE:
        begin
          mtime <= {`SLC_TCNT_W{1'b0}};
          if (locked && link_connected && unlock_req && pw_match) // RULE_01
          begin
            mstate   <= `SLC_ST_CW;
            motor_cw <= 1'b1; // RULE_02
          end
          else if (!locked && key_press) // RULE_04
          begin
            mstate    <= `SLC_ST_CCW;
            motor_ccw <= 1'b1; // RULE_03
          end
        end
        `SLC_ST_CW, `SLC_ST_CCW:
        begin
          if (tick)
            mtime <= mtime + 9'h001; // RULE_13
          // timeout guards against a stalled motor never giving an edge
          if (mc_edge || mtime == `SLC_MOTOR_TICKS)
          begin
            mstate    <= `SLC_ST_IDLE; // RULE_05
            motor_cw  <= 1'b0; // RULE_14
            motor_ccw <= 1'b0; // RULE_14
            locked    <= (mstate == `SLC_ST_CCW); // RULE_03
          end
        end
        default:
        begin
          mstate    <= `SLC_ST_IDLE;
          motor_cw  <= 1'b0;
          motor_ccw <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // alarm
  reg                   alarm;
  reg [`SLC_TCNT_W-1:0] btime;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      alarm  <= 1'b0;
      btime  <= `SLC_BUZZ_LAST;
      buzzer <= 1'b0;
    end
    else
    begin
      // a new break wins over a disarm in the same cycle
      if (locked && mstate == `SLC_ST_IDLE && ch_edge)
        alarm <= 1'b1; // RULE_06
      else if (link_rise)
        alarm <= 1'b0; // RULE_07
      // preloaded so the first alarm tick turns the buzzer on
      if (!alarm)
      begin
        btime  <= `SLC_BUZZ_LAST;
        buzzer <= 1'b0;
      end
      else if (tick) // RULE_13
      begin
        if (btime == `SLC_BUZZ_LAST)
        begin
          btime  <= {`SLC_TCNT_W{1'b0}};
          buzzer <= ~buzzer; // RULE_07
        end
        else
          btime <= btime + 9'h001;
      end
    end
  end

  // ==========================================================
  // battery sampling and link led
  reg [7:0] adc_div;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      adc_div       <= 8'h00;
      adc_start     <= 1'b0;
      battery_level <= 10'h000;
      link_led      <= 1'b0;
    end
    else
    begin
      link_led  <= link_connected; // RULE_12
      adc_start <= 1'b0;
      if (tick)
      begin
        if (adc_div == `SLC_ADC_PERIOD - 8'h01)
        begin
          adc_div   <= 8'h00;
          adc_start <= 1'b1; // RULE_09
        end
        else
          adc_div <= adc_div + 8'h01;
      end
      if (adc_valid)
        battery_level <= adc_data; // RULE_08
    end
  end
endmodule // slc_lock_ctrl
`default_nettype wire

// [hdl/slc_tick_timer.v]
`timescale 1ns/10ps
`default_nettype none
`include "slc_defs.vh"
module slc_tick_timer
  #(parameter TICK_CYCLES = `SLC_TICK_CYCLES)
  (
  input  wire mclk,
  input  wire reset,
  output reg  tick
  );

  reg [`SLC_TICK_W-1:0] count;

  // one-cycle pulse every 10 ms
  always @(posedge mclk)
  begin
    if (reset)
    begin
      count <= {`SLC_TICK_W{1'b0}};
      tick  <= 1'b0;
    end
    else if (count == TICK_CYCLES[`SLC_TICK_W-1:0] - 18'h00001)
    begin
      count <= {`SLC_TICK_W{1'b0}};
      tick  <= 1'b1; // RULE_13
    end
    else
    begin
      count <= count + 18'h00001;
      tick  <= 1'b0;
    end
  end
endmodule // slc_tick_timer
`default_nettype wire
